// ==== core/rcs_defines.vh ====
// Purpose: Constants for the receiver control and status register bank
// Assumes: 100 MHz reference clock, byte-wide registers
// Notes: Definitions only
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RCS_A_PRE_LEN 7'h0C
`define RCS_A_PRE_LO 7'h0D
`define RCS_A_PRE_HI 7'h0E
`define RCS_A_STRENGTH 7'h10
`define RCS_A_FERR 7'h11
`define RCS_A_DEMOD 7'h12
`define RCS_A_IRQ 7'h13
`define RCS_A_STATE_CTL 7'h14
`define RCS_A_RX_STATE 7'h15
`define RCS_A_TURN_ON 7'h16
`define RCS_A_LISTEN 7'h17
`define RCS_A_RATIO 7'h18
`define RCS_A_AFE 7'h19
`define RCS_A_IMG 7'h1A
`define RCS_A_PART 7'h1E
`define RCS_A_REV 7'h1F
`define RCS_A_LOCK 7'h27
`define RCS_A_CDR 7'h35

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCS_RST_PRE_LEN 4'hF
`define RCS_RST_TURN_ON 2'h3
`define RCS_RST_AFE 8'h0093
`define RCS_RST_ZERO 8'h00
// Arbitrary neutral identity values
`define RCS_PART_ID 8'h5A
`define RCS_REV_ID 3'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCS_SC_OSC 2
`define RCS_SC_WUT 1
`define RCS_SC_HRX 0
`define RCS_AFE_DLY 7:6
`define RCS_AFE_DIV 5:4
`define RCS_AFE_INJ 3
`define RCS_AFE_BAND 2:1
`define RCS_AFE_FRAC 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define RCS_CLK_NS 10
`define RCS_TICK_NS 80000
`define RCS_LISTEN_BASE 9'h006
`define RCS_DLY_16 7'h10
`define RCS_DLY_32 7'h20
`define RCS_DLY_64 7'h40
`define RCS_DIV_4 3'h3
`define RCS_DIV_5 3'h4
`define RCS_DIV_6 3'h5

// ----------------------------------------
// Serial port framing
// ----------------------------------------
`define RCS_CMD_BITS 4'h8
`define RCS_FRAME_BITS 5'h10
`define RCS_CMD_RD 7
`endif

// ==== core/rcs_regs.v ====
// Purpose: Receiver control and status registers behind a serial port
// Assumes: All inputs synchronous to ref_clk; serial clock is sampled
// Notes: Frame = command byte {rd, addr[6:0]} then one data byte, MSB first
`timescale 1ns/10ps
`default_nettype none
`include "rcs_defines.vh"

// How it works
// - Sync pattern length output is length field plus one; field resets to 15.
// - Sixteen-bit sync pattern built from low and high bytes, both reset zero.
// - Signal strength readable unsigned byte, reset zero, writes ignored.
// - Frequency error estimate readable signed byte, reset zero.
// - Demod filter value readable signed byte, reset zero.
// - Status bit 0 set on pattern found in poll listen; reset zero.
// - Recovery select: off, clock only, retime only, clock plus retime.
// - Bit 1 enables the wake timer, bit 0 host receive; reset off.
// - Receiver state readable: standby, host receive, poll wait, poll listen.
// - Front-end turn-on time 0.08 to 0.32 ms by code; resets code 3.
// - Poll listen lasts 0.48 ms plus 0.08 ms per duration count.
// - Oscillator clock gated after 0, 16, 32 or 64 cycles; resets 32.
// - Divider select divides by 4, 5, 6; code 3 invalid; resets 5.
// - Injection bit: clear low side, set high side.
// - Five-bit image trim field, writable, resets zero.
// - Revision register shows a 3-bit revision in low bits.
// - Lock status bit 0 reads one when the synthesizer is locked.
module rcs_regs #(
	parameter TICK_CYC = `RCS_TICK_NS / `RCS_CLK_NS
) (
	input wire ref_clk,
	input wire rst_n,
	input wire spi_cs_n,
	input wire spi_sclk,
	input wire spi_mosi,
	output reg spi_miso_q,
	output reg spi_miso_oe_n_q,
	input wire [7:0] signal_strength_in,
	input wire [7:0] freq_error_in,
	input wire [7:0] demod_filter_in,
	input wire sync_pattern_found,
	input wire pll_locked,
	output reg [4:0] sync_pattern_length_q,
	output reg [15:0] sync_pattern_bits_q,
	output reg cdr_clock_out_q,
	output reg cdr_retime_q,
	output reg oscillator_on_q,
	output reg osc_clk_gate_q,
	output reg osc_div_tick_q,
	output reg [1:0] rx_state_q,
	output reg frontend_ready_q,
	output reg [1:0] clock_recovery_select_q,
	output reg injection_side_q,
	output reg [1:0] band_divider_select_q,
	output reg fractional_synth_select_q,
	output reg [4:0] image_trim_q
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Receiver states, read back as the state field
	localparam [1:0] ST_SBY = 2'h0;
	localparam [1:0] ST_HRX = 2'h1;
	localparam [1:0] ST_WAIT = 2'h2;
	localparam [1:0] ST_LISTEN = 2'h3;
	reg [3:0] pre_len_q;
	reg [7:0] pre_lo_q, pre_hi_q;
	reg [7:0] strength_q, ferr_q, demod_q;
	reg found_q;
	reg [2:0] state_ctl_q;
	reg [1:0] turn_on_q;
	reg [7:0] listen_q;
	reg [6:0] ratio_q;
	reg [7:0] afe_q;
	reg lock_q;
	reg sclk_q;
	reg [4:0] bit_cnt_q;
	reg [7:0] shift_q;
	reg [7:0] cmd_q;
	reg [7:0] miso_sh_q;
	reg [14:0] tick_cnt_q;
	reg tick_q;
	reg [16:0] phase_q;
	reg [2:0] fe_cnt_q;
	reg [6:0] gate_cnt_q;
	reg [2:0] div_cnt_q;
	reg [1:0] st_d;
	reg [7:0] rd_data;
	reg [6:0] gate_lim;
	reg [2:0] div_lim;
	wire sclk_rise, sclk_fall, cmd_done, frame_done, wr_en;
	wire [6:0] wr_addr;
	wire [7:0] wr_data;
	wire clr_found;
	wire [8:0] listen_ticks;
	wire [16:0] wait_ticks;

	assign sclk_rise = !spi_cs_n && spi_sclk && !sclk_q;
	assign sclk_fall = !spi_cs_n && !spi_sclk && sclk_q;
	assign cmd_done = sclk_rise && bit_cnt_q == {1'b0, `RCS_CMD_BITS} - 5'h01;
	assign frame_done = sclk_rise && bit_cnt_q == `RCS_FRAME_BITS - 5'h01;
	assign wr_en = frame_done && !cmd_q[`RCS_CMD_RD];
	assign wr_addr = cmd_q[6:0];
	assign wr_data = {shift_q[6:0], spi_mosi};
	// Reading the status byte clears the flag
	assign clr_found = cmd_done && shift_q[`RCS_CMD_RD - 1]
		&& {shift_q[5:0], spi_mosi} == `RCS_A_IRQ;
	assign listen_ticks = `RCS_LISTEN_BASE + {1'b0, listen_q};
	// Wait is (1 + ratio) listens, giving duty 1/(2 + ratio)
	assign wait_ticks = {8'h00, listen_ticks}
		* ({10'h000, ratio_q} + 17'h00001);

	// ----------------------------------------
	// Serial port
	// ----------------------------------------
	// Sampling on rise, shifting on fall keeps mode 0 timing
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			bit_cnt_q <= 5'h00;
			shift_q <= `RCS_RST_ZERO;
			cmd_q <= `RCS_RST_ZERO;
			miso_sh_q <= `RCS_RST_ZERO;
			spi_miso_q <= 1'b0;
			spi_miso_oe_n_q <= 1'b1;
		end else begin
			sclk_q <= spi_sclk;
			spi_miso_oe_n_q <= spi_cs_n;
			if (spi_cs_n) begin
				bit_cnt_q <= 5'h00;
			end else if (sclk_rise) begin
				shift_q <= {shift_q[6:0], spi_mosi};
				bit_cnt_q <= frame_done ? 5'h00 : bit_cnt_q + 5'h01;
				if (cmd_done) begin
					cmd_q <= {shift_q[6:0], spi_mosi};
				end
			end
			// Answer byte latched with the command, sent MSB first
			if (cmd_done && shift_q[`RCS_CMD_RD - 1]) begin
				miso_sh_q <= rd_data;
			end else if (sclk_fall && bit_cnt_q >= {1'b0, `RCS_CMD_BITS}) begin
				spi_miso_q <= miso_sh_q[7];
				miso_sh_q <= {miso_sh_q[6:0], 1'b0};
			end
		end
	end

	// Read mux on the address just received
	always @* begin
		case ({shift_q[5:0], spi_mosi})
		`RCS_A_PRE_LEN: rd_data = {4'h0, pre_len_q};
		`RCS_A_PRE_LO: rd_data = pre_lo_q;
		`RCS_A_PRE_HI: rd_data = pre_hi_q;
		`RCS_A_STRENGTH: rd_data = strength_q;
		`RCS_A_FERR: rd_data = ferr_q;
		`RCS_A_DEMOD: rd_data = demod_q;
		`RCS_A_IRQ: rd_data = {7'h00, found_q};
		`RCS_A_STATE_CTL: rd_data = {5'h00, state_ctl_q};
		`RCS_A_RX_STATE: rd_data = {6'h00, rx_state_q};
		`RCS_A_TURN_ON: rd_data = {6'h00, turn_on_q};
		`RCS_A_LISTEN: rd_data = listen_q;
		`RCS_A_RATIO: rd_data = {1'b0, ratio_q};
		`RCS_A_AFE: rd_data = afe_q;
		`RCS_A_IMG: rd_data = {3'h0, image_trim_q};
		`RCS_A_PART: rd_data = `RCS_PART_ID;
		`RCS_A_REV: rd_data = {5'h00, `RCS_REV_ID};
		`RCS_A_LOCK: rd_data = {7'h00, lock_q};
		`RCS_A_CDR: rd_data = {6'h00, clock_recovery_select_q};
		default: rd_data = `RCS_RST_ZERO;
		endcase
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	// Read-only addresses and upper bits simply drop writes
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			pre_len_q <= `RCS_RST_PRE_LEN;
			pre_lo_q <= `RCS_RST_ZERO;
			pre_hi_q <= `RCS_RST_ZERO;
			state_ctl_q <= 3'h0;
			turn_on_q <= `RCS_RST_TURN_ON;
			listen_q <= `RCS_RST_ZERO;
			ratio_q <= 7'h00;
			afe_q <= `RCS_RST_AFE;
			image_trim_q <= 5'h00;
			clock_recovery_select_q <= 2'h0;
		end else if (wr_en) begin
			case (wr_addr)
			`RCS_A_PRE_LEN: pre_len_q <= wr_data[3:0];
			`RCS_A_PRE_LO: pre_lo_q <= wr_data;
			`RCS_A_PRE_HI: pre_hi_q <= wr_data;
			`RCS_A_STATE_CTL: state_ctl_q <= wr_data[2:0];
			`RCS_A_TURN_ON: turn_on_q <= wr_data[1:0];
			`RCS_A_LISTEN: listen_q <= wr_data;
			`RCS_A_RATIO: ratio_q <= wr_data[6:0];
			`RCS_A_AFE: afe_q <= wr_data;
			`RCS_A_IMG: image_trim_q <= wr_data[4:0];
			`RCS_A_CDR: clock_recovery_select_q <= wr_data[1:0];
			default: afe_q <= afe_q;
			endcase
		end
	end

	// ----------------------------------------
	// Measurements and status
	// ----------------------------------------
	// Set wins over the read clear so no detection is lost
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			strength_q <= `RCS_RST_ZERO;
			ferr_q <= `RCS_RST_ZERO;
			demod_q <= `RCS_RST_ZERO;
			found_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			strength_q <= signal_strength_in;
			ferr_q <= freq_error_in;
			demod_q <= demod_filter_in;
			lock_q <= pll_locked;
			if (sync_pattern_found && rx_state_q == ST_LISTEN) begin
				found_q <= 1'b1;
			end else if (clr_found) begin
				found_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Receiver state machine
	// ----------------------------------------
	// Listen holds after a detection until the host steps in
	always @* begin
		st_d = rx_state_q;
		if (!state_ctl_q[`RCS_SC_OSC]) begin
			st_d = ST_SBY;
		end else if (state_ctl_q[`RCS_SC_HRX]) begin
			st_d = ST_HRX;
		end else if (!state_ctl_q[`RCS_SC_WUT]) begin
			st_d = ST_SBY;
		end else begin
			case (rx_state_q)
			ST_WAIT: begin
				if (tick_q && phase_q >= wait_ticks - 17'h00001) begin
					st_d = ST_LISTEN;
				end
			end
			ST_LISTEN: begin
				if (!found_q && tick_q
					&& phase_q >= {8'h00, listen_ticks} - 17'h00001) begin
					st_d = ST_WAIT;
				end
			end
			default: st_d = ST_WAIT;
			endcase
		end
	end

	// Tick prescaler, phase timer and front-end turn-on count
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_state_q <= ST_SBY;
			tick_cnt_q <= 15'h0000;
			tick_q <= 1'b0;
			phase_q <= 17'h00000;
			fe_cnt_q <= 3'h0;
			frontend_ready_q <= 1'b0;
		end else begin
			rx_state_q <= st_d;
			tick_q <= tick_cnt_q == TICK_CYC[14:0] - 15'h0001;
			tick_cnt_q <= (tick_cnt_q == TICK_CYC[14:0] - 15'h0001)
				? 15'h0000 : tick_cnt_q + 15'h0001;
			if (st_d != rx_state_q) begin
				tick_cnt_q <= 15'h0001; // Whole ticks in every state
				tick_q <= 1'b0;
				phase_q <= 17'h00000;
				fe_cnt_q <= 3'h0;
				frontend_ready_q <= 1'b0;
			end else begin
				if (tick_q) begin
					phase_q <= phase_q + 17'h00001;
				end
				// Front end ready after (code + 1) ticks of 0.08 ms
				if (rx_state_q[0] && tick_q && !frontend_ready_q) begin
					fe_cnt_q <= fe_cnt_q + 3'h1;
					frontend_ready_q <= fe_cnt_q == {1'b0, turn_on_q};
				end
			end
		end
	end

	// ----------------------------------------
	// Oscillator gate and divider
	// ----------------------------------------
	always @* begin
		case (afe_q[`RCS_AFE_DLY])
		2'h0: gate_lim = 7'h00;
		2'h1: gate_lim = `RCS_DLY_16;
		2'h2: gate_lim = `RCS_DLY_32;
		default: gate_lim = `RCS_DLY_64;
		endcase
		case (afe_q[`RCS_AFE_DIV])
		2'h0: div_lim = `RCS_DIV_4;
		2'h1: div_lim = `RCS_DIV_5;
		default: div_lim = `RCS_DIV_6;
		endcase
	end

	// Invalid divider code holds the divider idle
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			gate_cnt_q <= 7'h00;
			osc_clk_gate_q <= 1'b0;
			div_cnt_q <= 3'h0;
			osc_div_tick_q <= 1'b0;
		end else begin
			if (!state_ctl_q[`RCS_SC_OSC]) begin
				gate_cnt_q <= 7'h00;
				osc_clk_gate_q <= 1'b0;
			end else if (gate_cnt_q >= gate_lim) begin
				osc_clk_gate_q <= 1'b1;
			end else begin
				gate_cnt_q <= gate_cnt_q + 7'h01;
			end
			if (!osc_clk_gate_q || afe_q[`RCS_AFE_DIV] == 2'h3) begin
				div_cnt_q <= 3'h0;
				osc_div_tick_q <= 1'b0;
			end else begin
				osc_div_tick_q <= div_cnt_q == div_lim;
				div_cnt_q <= (div_cnt_q == div_lim) ? 3'h0 : div_cnt_q + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Registered configuration outputs
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			sync_pattern_length_q <= 5'h00;
			sync_pattern_bits_q <= 16'h0000;
			cdr_clock_out_q <= 1'b0;
			cdr_retime_q <= 1'b0;
			oscillator_on_q <= 1'b0;
			injection_side_q <= 1'b0;
			band_divider_select_q <= 2'h0;
			fractional_synth_select_q <= 1'b0;
		end else begin
			sync_pattern_length_q <= {1'b0, pre_len_q} + 5'h01;
			sync_pattern_bits_q <= {pre_hi_q, pre_lo_q};
			cdr_clock_out_q <= clock_recovery_select_q[0];
			cdr_retime_q <= clock_recovery_select_q[1];
			oscillator_on_q <= state_ctl_q[`RCS_SC_OSC];
			injection_side_q <= afe_q[`RCS_AFE_INJ];
			band_divider_select_q <= afe_q[`RCS_AFE_BAND];
			fractional_synth_select_q <= afe_q[`RCS_AFE_FRAC];
		end
	end

endmodule
`default_nettype wire

// ==== dv/rcs_chk.sv ====
// Purpose: Timing checks on the receiver register bank outputs
// Assumes: One ref_clk domain, rst_n synchronous active low
// Notes: Bound to rcs_regs and sees only its ports
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module rcs_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [4:0] sync_pattern_length_q,
	input wire logic oscillator_on_q,
	input wire logic osc_clk_gate_q,
	input wire logic osc_div_tick_q,
	input wire logic [1:0] rx_state_q,
	input wire logic frontend_ready_q,
	input wire logic [1:0] clock_recovery_select_q,
	input wire logic cdr_clock_out_q,
	input wire logic cdr_retime_q
);
	// Single domain, so clock and disable are shared
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Length is field plus one, so never zero and never above 16
	property p_len;
		$past(rst_n, 2) |-> sync_pattern_length_q != 5'h00 &&
			sync_pattern_length_q <= 5'h10;
	endproperty
	a_len: assert property (p_len) else $error("length out of range");
	// Oscillator off forces standby
	property p_osc;
		!oscillator_on_q [*3] |-> rx_state_q == 2'h0;
	endproperty
	a_osc: assert property (p_osc) else $error("state without osc");
	// Gate never opens while the oscillator is off
	property p_gate;
		$rose(osc_clk_gate_q) |-> oscillator_on_q;
	endproperty
	a_gate: assert property (p_gate) else $error("gate without osc");
	// Divider ticks only behind an open gate, one cycle of slack
	property p_tick;
		osc_div_tick_q |-> osc_clk_gate_q || $past(osc_clk_gate_q);
	endproperty
	a_tick: assert property (p_tick) else $error("tick while gated off");
	// Smallest divide ratio is four
	property p_gap;
		osc_div_tick_q |=> !osc_div_tick_q [*3];
	endproperty
	a_gap: assert property (p_gap) else $error("ticks too close");
	// Settled select drives the recovery outputs
	property p_cdr;
		$stable(clock_recovery_select_q) |->
			cdr_clock_out_q == clock_recovery_select_q[0] &&
			cdr_retime_q == clock_recovery_select_q[1];
	endproperty
	a_cdr: assert property (p_cdr) else $error("recovery decode");
	// Front end comes up only in a receive state
	property p_rdy;
		$rose(frontend_ready_q) |-> rx_state_q == 2'h1 || rx_state_q == 2'h3;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready outside rx");
	// A fresh state restarts the turn-on wait
	property p_rdy_new;
		$changed(rx_state_q) |-> ##2 !frontend_ready_q;
	endproperty
	a_rdy_new: assert property (p_rdy_new) else $error("ready too soon");
endmodule
bind rcs_regs rcs_chk i_chk (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.sync_pattern_length_q(sync_pattern_length_q),
	.oscillator_on_q(oscillator_on_q),
	.osc_clk_gate_q(osc_clk_gate_q),
	.osc_div_tick_q(osc_div_tick_q),
	.rx_state_q(rx_state_q),
	.frontend_ready_q(frontend_ready_q),
	.clock_recovery_select_q(clock_recovery_select_q),
	.cdr_clock_out_q(cdr_clock_out_q),
	.cdr_retime_q(cdr_retime_q)
);
`default_nettype wire

// ==== dv/rcs_host.sv ====
// Purpose: Host controller model driving the serial register port
// Assumes: Called at a falling ref_clk edge; sclk still outside frames
// Notes: Command byte then data byte, MSB first
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Host model
// ----------------------------------------
module rcs_host (
	input wire logic ref_clk,
	input wire logic miso,
	output logic cs_n,
	output logic sclk,
	output logic mosi
);
	// Idle levels before the first frame
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// Three cycles a half, since sclk is only sampled by the device
	task automatic frame(input logic [7:0] c, input logic [7:0] d,
		output logic [7:0] r);
		logic [15:0] w;
		w = {c, d};
		r = 8'h00;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = w[i];
			repeat (3) @(negedge ref_clk);
			sclk = 1'b1;
			if (i < 8) begin
				r[i] = miso;
			end
			repeat (3) @(negedge ref_clk);
			sclk = 1'b0;
		end
		repeat (3) @(negedge ref_clk);
		cs_n = 1'b1;
		mosi = ~mosi;
		repeat (3) @(negedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the receiver register bank
// Assumes: Inputs change on falling ref_clk edges
// Notes: TICK_CYC cut to 4 so poll timings stay short
`timescale 1ns/10ps
`default_nettype none
`include "rcs_defines.vh"
module tb;
	localparam int TK = 4;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] ss = 8'h00, fe = 8'h00, df = 8'h00, r;
	logic found = 1'b0, lock = 1'b0;
	int fail_count = 0, n_tests = 0, n;
	wire cs_n, sclk, mosi, miso_w, miso, oe_n, cdr_c, cdr_r, osc_on, gate;
	wire tick, ready, inj, frac;
	wire [4:0] len, trim;
	wire [15:0] pat;
	wire [1:0] st, cdr_s, band;
	logic [15:0] rv [0:14] = '{16'h0C0F, 16'h0D00, 16'h0E00, 16'h1000,
		16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h1500, 16'h1603,
		16'h1993, 16'h1A00, 16'h2700, 16'h3500, 16'h2000};
	// Clock
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Released line shows the inverse, never a held value
	assign miso_w = oe_n ? ~miso : miso;
	rcs_host i_host (.ref_clk(ref_clk), .miso(miso_w), .cs_n(cs_n),
		.sclk(sclk), .mosi(mosi));
	rcs_regs #(.TICK_CYC(TK)) i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .spi_cs_n(cs_n),
		.spi_sclk(sclk), .spi_mosi(mosi), .spi_miso_q(miso),
		.spi_miso_oe_n_q(oe_n), .signal_strength_in(ss),
		.freq_error_in(fe), .demod_filter_in(df),
		.sync_pattern_found(found), .pll_locked(lock),
		.sync_pattern_length_q(len), .sync_pattern_bits_q(pat),
		.cdr_clock_out_q(cdr_c), .cdr_retime_q(cdr_r),
		.oscillator_on_q(osc_on), .osc_clk_gate_q(gate),
		.osc_div_tick_q(tick), .rx_state_q(st), .frontend_ready_q(ready),
		.clock_recovery_select_q(cdr_s), .injection_side_q(inj),
		.band_divider_select_q(band), .fractional_synth_select_q(frac),
		.image_trim_q(trim));
	// Compare and count
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task complete_run;
		if (fail_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		i_host.frame({1'b0, a}, d, r);
	endtask
	task rchk(input logic [6:0] a, input logic [7:0] e);
		i_host.frame({1'b1, a}, 8'h00, r);
		chk(r, e);
	endtask
	// Observed signal by index
	function automatic logic [1:0] pick(input int s);
		case (s)
			0: pick = st;
			1: pick = {1'b0, gate};
			2: pick = {1'b0, ready};
			3: pick = {1'b0, tick};
			default: pick = {1'b0, osc_on};
		endcase
	endfunction
	// Bounded wait until equal (eq) or while equal; n holds cycles
	task wt(input int s, input logic [1:0] v, input bit eq);
		for (n = 0; n < 3000 && (pick(s) === v) != eq; n++) begin
			@(negedge ref_clk);
		end
		if (n >= 3000) begin
			fail_count++;
			complete_run();
		end
	endtask
	task t_reset;
		chk({3'h0, len}, 8'h10);
		chk(pat[15:8] | pat[7:0], 8'h00);
		for (int i = 0; i < 15; i++) begin
			rchk(rv[i][14:8], rv[i][7:0]);
		end
		rchk(7'h1F, {5'h00, `RCS_REV_ID});
	endtask
	task t_rw;
		wr(7'h0D, 8'hA5);
		wr(7'h0E, 8'h3C);
		wr(7'h0C, 8'hF3);
		wr(7'h1A, 8'hEA);
		wr(7'h10, 8'hFF);
		chk(pat[15:8], 8'h3C);
		chk(pat[7:0], 8'hA5);
		chk({3'h0, len}, 8'h04);
		chk({3'h0, trim}, 8'h0A);
		rchk(7'h0C, 8'h03);
		rchk(7'h1A, 8'h0A);
		rchk(7'h10, 8'h00);
		for (int i = 0; i < 4; i++) begin
			logic [1:0] b;
			b = 2'(i);
			wr(7'h35, {6'h3F, b});
			wr(7'h19, {4'h9, b[0], b, 1'b1});
			chk({6'h0, cdr_s}, {6'h0, b});
			chk({6'h0, cdr_r, cdr_c}, {6'h0, b});
			chk({4'h0, inj, band, frac}, {4'h0, b[0], b, 1'b1});
			rchk(7'h35, {6'h0, b});
		end
	endtask
	// Gate delay and divider spacing from the oscillator start
	task t_osc;
		// Each delay code from a cold start, divide by 5 kept
		for (int k = 0; k < 4; k++) begin
			wr(7'h14, 8'h00);
			wr(7'h19, {2'(k), 6'h13});
			fork
				wr(7'h14, 8'h04);
				begin
					wt(4, 2'h1, 1'b1);
					wt(1, 2'h1, 1'b1);
					chk(8'(n), (k == 0) ? 8'h00 : 8'(8 << k));
				end
			join
		end
		for (int i = 5; i > 3; i--) begin
			wt(3, 2'h1, 1'b1);
			@(negedge ref_clk);
			wt(3, 2'h1, 1'b1);
			chk(8'(n), 8'(i - 1));
			wr(7'h19, 8'h83);
		end
		wr(7'h19, 8'hB3);
		n = 0;
		repeat (40) begin
			@(negedge ref_clk);
			n += (tick !== 1'b0);
		end
		chk(8'(n), 8'h00);
		wr(7'h19, 8'h93);
	endtask
	task t_ro;
		ss = 8'h81;
		fe = 8'h80;
		df = 8'h7F;
		lock = 1'b1;
		found = 1'b1;
		rchk(7'h10, 8'h81);
		rchk(7'h11, 8'h80);
		rchk(7'h12, 8'h7F);
		rchk(7'h27, 8'h01);
		rchk(7'h1E, `RCS_PART_ID);
		rchk(7'h13, 8'h00);
		found = 1'b0;
	endtask
	// Shortest and reset turn-on codes, reset code left behind
	task t_hrx;
		for (int c = 0; c < 4; c += 3) begin
			wr(7'h16, 8'(c));
			fork
				wr(7'h14, 8'h05);
				begin
					wt(0, 2'h1, 1'b1);
					wt(2, 2'h1, 1'b1);
					chk(8'(n), 8'((c + 1) * TK));
				end
			join
			rchk(7'h15, 8'h01);
			wr(7'h14, 8'h04);
			rchk(7'h15, 8'h00);
		end
	endtask
	// Self-polling timing, then a find that holds the listen phase
	task t_poll;
		wr(7'h17, 8'h01);
		wr(7'h18, 8'h81);
		wr(7'h14, 8'h06);
		wt(0, 2'h3, 1'b1);
		wt(0, 2'h3, 1'b0);
		chk(8'(n), 8'(7 * TK));
		wt(0, 2'h2, 1'b0);
		chk(8'(n), 8'(14 * TK));
		found = 1'b1;
		@(negedge ref_clk);
		found = 1'b0;
		repeat (40) @(negedge ref_clk);
		chk({6'h0, st}, 8'h03);
		rchk(7'h13, 8'h01);
		rchk(7'h13, 8'h00);
		rchk(7'h18, 8'h01);
		wr(7'h14, 8'h00);
		repeat (4) @(negedge ref_clk);
		chk({6'h0, st}, 8'h00);
	endtask
	// Main sequence
	initial begin
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		t_reset();
		t_rw();
		t_osc();
		t_ro();
		t_hrx();
		t_poll();
		complete_run();
	end
endmodule
`default_nettype wire
